// ---- tb_vectored_interrupt_unit.sv ----
module tb_vectored_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import vui_pkg::*;
  logic        clock, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, slow, rom_req;
  logic        instr_boundary, ir_force, trap_busy, trap_push_req;
  logic        trap_pc_load, exec_vis, exec_return_from_irq_instr, exec_clear_trap_pending_instr, rom_ack;
  logic        jump_valid, global_irq_enable, sw_trap_pending;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, next_opcode, ir_opcode, rom_data;
  logic [11:0] src_event;
  logic [14:0] next_pc, trap_push_addr, trap_pc_value, vis_pc;
  logic [14:0] rom_addr, jump_target;
  logic [31:0] wdata, rdata, rng;
  logic [14:0] exp_q[$];
  int          miscompares, num_checks;

  vui_vectored_irq_unit DUT (.clock, .reset_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src_event,
    .instr_boundary, .next_opcode, .next_pc, .ir_force, .ir_opcode,
    .trap_busy, .trap_push_req, .trap_push_addr, .trap_pc_load,
    .trap_pc_value, .exec_vis, .vis_pc, .exec_return_from_irq_instr, .exec_clear_trap_pending_instr, .rom_req,
    .rom_addr, .rom_ack, .rom_data, .jump_valid, .jump_target,
    .global_irq_enable, .sw_trap_pending);
  vui_rom_model rom (.clock, .reset_n, .slow, .rom_req, .rom_addr,
    .rom_ack, .rom_data);

  // free running cycle clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // target the rom model hands back for a slot, page worked out here
  function automatic logic [14:0] vt(logic [14:0] pc, logic [7:0] s);
    logic [6:0] p;
    logic [7:0] h, l;
    p = pc[14:8] + {6'h00, pc[7:0] == 8'hFF};
    if (p == 7'h00) p = 7'h01;
    h = s ^ {1'b0, p};
    l = (s + 8'h01) ^ {1'b0, p};
    return {h[6:0], l};
  endfunction

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(negedge clock);
      ad |= awvalid & awready;
      wd |= wvalid & wready;
      @(posedge clock);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    @(negedge clock);
    while (!bvalid) @(negedge clock);
    chk("bresp", bresp, er);
    @(posedge clock);
    bready <= 1'b0;
  endtask

  task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    @(negedge clock);
    while (!arready) @(negedge clock);
    @(posedge clock);
    arvalid <= 1'b0;
    @(negedge clock);
    while (!rvalid) @(negedge clock);
    chk("rresp", rresp, er);
    chk("rdata", rdata, ed);
    @(posedge clock);
    rready <= 1'b0;
  endtask

  task automatic src(logic [11:0] m);
    @(posedge clock);
    src_event <= m;
    @(posedge clock);
    src_event <= 12'h000;
  endtask

  task automatic bnd(logic [7:0] op, logic [14:0] pc, logic ef, logic et);
    @(posedge clock);
    {instr_boundary, next_opcode, next_pc} <= {1'b1, op, pc};
    @(negedge clock);
    chk("force", ir_force, ef);
    if (ef) chk("opcode", ir_opcode, 8'h00);
    @(posedge clock);
    instr_boundary <= 1'b0;
    @(negedge clock);
    if (et) begin
      chk("push", {trap_push_req, trap_push_addr}, {1'b1, pc});
      if (ef) chk("gie", global_irq_enable, 1'b0);
      repeat (6) @(negedge clock);
      chk("load", {trap_pc_load, trap_pc_value}, 16'h80FF);
      @(negedge clock);
    end
    chk("busy", trap_busy, 1'b0);
  endtask

  task automatic vector_select_instr(logic [14:0] pc, logic [7:0] s);
    void'(xs());
    @(posedge clock);
    {exec_vis, vis_pc, slow} <= {1'b1, pc, rng[3]};
    exp_q.push_back(vt(pc, s));
    @(posedge clock);
    exec_vis <= 1'b0;
    while (exp_q.size() != 0) @(posedge clock);
  endtask

  task automatic pulse_return_from_irq_instr();
    @(posedge clock);
    exec_return_from_irq_instr <= 1'b1;
    @(posedge clock);
    exec_return_from_irq_instr <= 1'b0;
    @(negedge clock);
    chk("gie", global_irq_enable, 1'b1);
  endtask

  // each jump is compared with the oldest noted target
  always @(negedge clock) begin
    if (jump_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("jump", 1, 0);
      else chk("jump", jump_target, exp_q.pop_front());
    end
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    close_out();
  end

  initial begin
    rng = 32'hF3FB;
    {awvalid, wvalid, bready, arvalid, rready, instr_boundary} = '0;
    {exec_vis, exec_return_from_irq_instr, exec_clear_trap_pending_instr, slow, awaddr, araddr, wdata} = '0;
    {wstrb, src_event, next_opcode, next_pc, vis_pc} = '0;
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("rst", {global_irq_enable, sw_trap_pending}, 2'b00);
    axr(VUI_REG_ENABLE, 32'h0, VUI_RESP_OKAY);
    axw(VUI_REG_ENABLE, 32'hFFF, VUI_RESP_OKAY);
    axr(VUI_REG_ENABLE, 32'hFFF, VUI_RESP_OKAY);
    axr(8'h10, 32'h0, VUI_RESP_SLVERR);
    axw(8'h10, 32'h1, VUI_RESP_SLVERR);
    vector_select_instr(15'h0042, 8'hE0);
    vector_select_instr(15'h12FF, 8'hE0);
    for (int i = 0; i < 12; i++) begin
      src(12'((13'h2 << i) - 13'h1));
      vector_select_instr(15'(xs()), 8'hE2 + 8'(2 * i) + (i > 6 ? 8'h2 : 8'h0));
      axw(VUI_REG_PENDING, 32'hFFF, VUI_RESP_OKAY);
    end
    axw(VUI_REG_ENABLE, 32'h7FF, VUI_RESP_OKAY);
    src(12'h801);
    vector_select_instr(15'h0300, 8'hE2);
    axw(VUI_REG_ENABLE, 32'hFFF, VUI_RESP_OKAY);
    axw(VUI_REG_PENDING, 32'hFFF, VUI_RESP_OKAY);
    axw(VUI_REG_CTRL, 32'h1, VUI_RESP_OKAY);
    axr(VUI_REG_CTRL, 32'h1, VUI_RESP_OKAY);
    src(12'h208);
    bnd(8'h55, 15'h1234, 1'b1, 1'b1);
    vector_select_instr(15'h0500, 8'hF6);
    axw(VUI_REG_PENDING, 32'h200, VUI_RESP_OKAY);
    pulse_return_from_irq_instr();
    bnd(8'h55, 15'h0777, 1'b1, 1'b1);
    bnd(8'h55, 15'h0778, 1'b0, 1'b0);
    axw(VUI_REG_PENDING, 32'h008, VUI_RESP_OKAY);
    pulse_return_from_irq_instr();
    bnd(8'h00, 15'h07FF, 1'b0, 1'b1);
    chk("trap", {sw_trap_pending, global_irq_enable}, 2'b11);
    src(12'h008);
    axr(VUI_REG_STATUS, 32'h0001_0008, VUI_RESP_OKAY);
    bnd(8'h55, 15'h0100, 1'b0, 1'b0);
    vector_select_instr(15'h0600, 8'hFE);
    bnd(8'h00, 15'h0101, 1'b0, 1'b1);
    @(posedge clock);
    exec_clear_trap_pending_instr <= 1'b1;
    @(posedge clock);
    exec_clear_trap_pending_instr <= 1'b0;
    @(negedge clock);
    chk("latch", sw_trap_pending, 1'b0);
    bnd(8'h55, 15'h0102, 1'b1, 1'b1);
    close_out();
  end
endmodule

// ---- vui_axil_slave.sv ----
module vui_axil_slave
  import vui_pkg::*;
(
  input  wire logic              clock,     // cycle clock
  input  wire logic              reset_n,   // async reset
  input  wire logic [VUI_AW-1:0] awaddr,    // write address
  input  wire logic              awvalid,   // write address valid
  output logic                   awready,   // write address ready
  input  wire logic [31:0]       wdata,     // write data
  input  wire logic [3:0]        wstrb,     // byte enables
  input  wire logic              wvalid,    // write data valid
  output logic                   wready,    // write data ready
  output logic [1:0]             bresp,     // write response
  output logic                   bvalid,    // write response valid
  input  wire logic              bready,    // write response ready
  input  wire logic [VUI_AW-1:0] araddr,    // read address
  input  wire logic              arvalid,   // read address valid
  output logic                   arready,   // read address ready
  output logic [31:0]            rdata,     // read data
  output logic [1:0]             rresp,     // read response
  output logic                   rvalid,    // read data valid
  input  wire logic              rready,    // read data ready
  output logic                   reg_wr,    // write strobe
  output logic [VUI_AW-1:0]      reg_waddr, // write address
  output logic [31:0]            reg_wdata, // write data
  output logic [3:0]             reg_wstrb, // write lanes
  input  wire logic              reg_werr,  // write address unmapped
  output logic                   reg_rd,    // read strobe
  input  wire logic [31:0]       reg_rdata, // read value for araddr
  input  wire logic              reg_rerr   // read address unmapped
);
  logic aw_full_q, w_full_q;

  // each channel is held until the response has gone out
  assign awready = !aw_full_q && !bvalid;
  assign wready  = !w_full_q && !bvalid;
  assign reg_wr  = aw_full_q && w_full_q && !bvalid;
  assign arready = !rvalid;
  assign reg_rd  = arvalid && arready;

  // address and data taken in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= '0;
      reg_wstrb <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        reg_waddr <= awaddr;
      end else if (reg_wr) begin
        aw_full_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_q  <= 1'b1;
        reg_wdata <= wdata;
        reg_wstrb <= wstrb;
      end else if (reg_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // responses
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= VUI_RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= VUI_RESP_OKAY;
      rdata  <= '0;
    end else begin
      if (reg_wr) begin
        bvalid <= 1'b1;
        bresp  <= reg_werr ? VUI_RESP_SLVERR : VUI_RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (reg_rd) begin
        rvalid <= 1'b1;
        rdata  <= reg_rdata;
        rresp  <= reg_rerr ? VUI_RESP_SLVERR : VUI_RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- vui_pkg.sv ----
package vui_pkg;
  // source count and bit positions; a higher index ranks higher
  localparam int VUI_NSRC                  = 12;
  localparam int VUI_SRC_WAKEUP_EDGE       = 0;
  localparam int VUI_SRC_TIMER3_CAPTURE_B  = 1;
  localparam int VUI_SRC_TIMER3_CAPTURE_A  = 2;
  localparam int VUI_SRC_TIMER2_CAPTURE_B  = 3;
  localparam int VUI_SRC_TIMER2_CAPTURE_A  = 4;
  localparam int VUI_SRC_UART_TX           = 5;
  localparam int VUI_SRC_UART_RX           = 6;
  localparam int VUI_SRC_SERIAL_BUSY_FALL  = 7;
  localparam int VUI_SRC_TIMER1_CAPTURE_B  = 8;
  localparam int VUI_SRC_TIMER1_CAPTURE_A  = 9;
  localparam int VUI_SRC_IDLE_TIMER        = 10;
  localparam int VUI_SRC_EXTERNAL_IRQ_PIN  = 11;

  // vector slot (high byte offset in the page) per source index
  localparam logic [7:0] VUI_SLOT [VUI_NSRC] = '{
    8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC,
    8'hEE, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA};
  localparam logic [7:0] VUI_SLOT_SW_TRAP = 8'hFE;
  localparam logic [7:0] VUI_SLOT_DEFAULT = 8'hE0;
  localparam logic [7:0] VUI_PAGE_LAST    = 8'hFF;
  localparam logic [6:0] VUI_PAGE_ZERO    = 7'h00;
  localparam logic [6:0] VUI_PAGE_ONE     = 7'h01;

  // trap entry
  localparam logic [7:0]  VUI_FORCED_TRAP_OPCODE = 8'h00;
  localparam logic [14:0] VUI_TRAP_ENTRY         = 15'h00FF;
  localparam logic [2:0]  VUI_TRAP_CYCLES        = 3'h7;

  // register map (byte addresses)
  localparam int          VUI_AW          = 8;
  localparam logic [7:0]  VUI_REG_CTRL    = 8'h00;
  localparam logic [7:0]  VUI_REG_ENABLE  = 8'h04;
  localparam logic [7:0]  VUI_REG_PENDING = 8'h08;
  localparam logic [7:0]  VUI_REG_STATUS  = 8'h0C;
  localparam int          VUI_CTRL_GIE_BIT       = 0;
  localparam int          VUI_STAT_TRAP_PEND_BIT = 16;
  localparam int          VUI_STAT_BUSY_BIT      = 17;
  localparam logic        VUI_GIE_RST     = 1'b0;
  localparam logic [11:0] VUI_ENABLE_RST  = 12'h000;
  localparam logic [11:0] VUI_PENDING_RST = 12'h000;

  // bus answers
  localparam logic [1:0] VUI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VUI_RESP_SLVERR = 2'h2;

  // vector fetch sequencer, gray along idle-hi-lo-jump
  typedef enum logic [1:0] {
    VUI_VS_IDLE = 2'h0,
    VUI_VS_HI   = 2'h1,
    VUI_VS_LO   = 2'h3,
    VUI_VS_JUMP = 2'h2
  } vui_vis_state_t;
endpackage

// ---- vui_prio_enc.sv ----
module vui_prio_enc
  import vui_pkg::*;
#(
  parameter int N  = VUI_NSRC,
  parameter int IW = $clog2(N)
) (
  input  wire logic [N-1:0]  req,   // active sources
  output logic               found, // any active
  output logic [IW-1:0]      index  // highest active index
);
  // scan upward so the highest set bit is left standing
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        found = 1'b1;
        index = IW'(i);
      end
    end
  end
endmodule

// ---- vui_rom_model.sv ----
module vui_rom_model (
  input  wire logic        clock,    // cycle clock
  input  wire logic        reset_n,  // async reset
  input  wire logic        slow,     // add wait cycles
  input  wire logic        rom_req,  // byte request
  input  wire logic [14:0] rom_addr, // byte address
  output logic             rom_ack,  // byte returned
  output logic [7:0]       rom_data  // byte value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;

  // byte depends on page too, so a wrong page shows in the target
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rom_ack  <= 1'b0;
      rom_data <= 8'hA5;
      wait_q   <= 2'h0;
    end else begin
      rom_ack  <= 1'b0;
      rom_data <= ~rom_data; // junk outside the ack cycle
      if (!rom_req) begin
        wait_q <= slow ? 2'h2 : 2'h0;
      end else if (!rom_ack) begin
        if (wait_q == 2'h0) begin
          rom_ack  <= 1'b1;
          rom_data <= rom_addr[7:0] ^ {1'b0, rom_addr[14:8]};
          wait_q   <= slow ? 2'h2 : 2'h0;
        end else begin
          wait_q <= wait_q - 2'h1;
        end
      end
    end
  end
endmodule

// ---- vui_vectored_irq_unit.sv ----
// Behaviour
// - thirteen sources, each with fixed rank and two-byte vector slot
// - all sources but the software trap have enable and pending flags
// - a maskable source is active only when enabled and pending
// - global enable plus active source interrupts at next boundary
// - interruption substitutes opcode 00 into the instruction register
// - forced trap clears global enable, pushes address, loads 00FF, 7 cycles
// - fixed priority order, software trap highest, default lowest
// - vector slots ascend with rank from E0 up to FA, trap FE
// - vector select picks the highest active source when it executes
// - losing sources stay pending and interrupt again after return
// - return from interrupt sets the global enable
// - each vector is a 15-bit target in two consecutive bytes
// - vector table in vector-select page, next page if last; never zero
// - vector select with nothing active uses the default slot E0
// - fetching the trap opcode from memory raises a software trap
// - trap latch keeps global enable, blocks others, steers vector select
// - trap latch cleared only by clear-pending instruction or reset
// - only another software trap interrupts a software trap service
module vui_vectored_irq_unit
  import vui_pkg::*;
(
  input  wire logic                clock,          // instruction clock
  input  wire logic                reset_n,        // async reset
  input  wire logic [VUI_AW-1:0]   awaddr,         // axi write address
  input  wire logic                awvalid,        // axi
  output logic                     awready,        // axi
  input  wire logic [31:0]         wdata,          // axi write data
  input  wire logic [3:0]          wstrb,          // axi byte enables
  input  wire logic                wvalid,         // axi
  output logic                     wready,         // axi
  output logic [1:0]               bresp,          // axi
  output logic                     bvalid,         // axi
  input  wire logic                bready,         // axi
  input  wire logic [VUI_AW-1:0]   araddr,         // axi read address
  input  wire logic                arvalid,        // axi
  output logic                     arready,        // axi
  output logic [31:0]              rdata,          // axi read data
  output logic [1:0]               rresp,          // axi
  output logic                     rvalid,         // axi
  input  wire logic                rready,         // axi
  input  wire logic [VUI_NSRC-1:0] src_event,      // source event pulses
  input  wire logic                instr_boundary, // about to execute
  input  wire logic [7:0]          next_opcode,    // fetched opcode
  input  wire logic [14:0]         next_pc,        // its address
  output logic                     ir_force,       // substitute opcode
  output logic [7:0]               ir_opcode,      // opcode substituted
  output logic                     trap_busy,      // trap sequence running
  output logic                     trap_push_req,  // push return address
  output logic [14:0]              trap_push_addr, // return address
  output logic                     trap_pc_load,   // load entry point
  output logic [14:0]              trap_pc_value,  // entry point
  input  wire logic                exec_vis,       // vector_select_instr
  input  wire logic [14:0]         vis_pc,         // its address
  input  wire logic                exec_return_from_irq_instr,      // return_from_irq_instr
  input  wire logic                exec_clear_trap_pending_instr,      // clear_trap_pending_instr
  output logic                     rom_req,        // vector byte request
  output logic [14:0]              rom_addr,       // vector byte address
  input  wire logic                rom_ack,        // byte returned
  input  wire logic [7:0]          rom_data,       // byte value
  output logic                     jump_valid,     // indirect jump pulse
  output logic [14:0]              jump_target,    // jump address
  output logic                     global_irq_enable, // enable state
  output logic                     sw_trap_pending // hidden trap latch
);
  logic                gie_q, trap_pend_q, busy_q;
  logic [VUI_NSRC-1:0] enable_q, pending_q, active;
  logic [2:0]          cnt_q;
  logic                take, st_hit, found;
  logic [3:0]          top_idx;
  logic                reg_wr, reg_rd, reg_werr, reg_rerr;
  logic [VUI_AW-1:0]   reg_waddr;
  logic [31:0]         reg_wdata, reg_rdata;
  logic [3:0]          reg_wstrb;
  logic [15:0]         wmask;
  logic                wr_ctrl, wr_en, wr_pend;
  vui_vis_state_t      vs_q;
  logic [6:0]          page;
  logic [6:0]          tgt_hi_q;

  vui_axil_slave u_bus (
    .clock     (clock),
    .reset_n   (reset_n),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .reg_werr  (reg_werr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .reg_rerr  (reg_rerr)
  );

  // write decode; only the two low byte lanes hold bits
  assign wmask   = {{8{reg_wstrb[1]}}, {8{reg_wstrb[0]}}};
  assign wr_ctrl = reg_wr && reg_waddr == VUI_REG_CTRL;
  assign wr_en   = reg_wr && reg_waddr == VUI_REG_ENABLE;
  assign wr_pend = reg_wr && reg_waddr == VUI_REG_PENDING;
  assign reg_werr = !(reg_waddr == VUI_REG_CTRL ||
                      reg_waddr == VUI_REG_ENABLE ||
                      reg_waddr == VUI_REG_PENDING ||
                      reg_waddr == VUI_REG_STATUS);

  // read mux; unmapped reads give zero with an error
  always_comb begin
    reg_rdata = 32'h0000_0000;
    reg_rerr  = 1'b0;
    unique case (araddr)
      VUI_REG_CTRL:    reg_rdata[VUI_CTRL_GIE_BIT] = gie_q;
      VUI_REG_ENABLE:  reg_rdata[VUI_NSRC-1:0] = enable_q;
      VUI_REG_PENDING: reg_rdata[VUI_NSRC-1:0] = pending_q;
      VUI_REG_STATUS: begin
        reg_rdata[VUI_NSRC-1:0]          = active;
        reg_rdata[VUI_STAT_TRAP_PEND_BIT] = trap_pend_q;
        reg_rdata[VUI_STAT_BUSY_BIT]      = busy_q;
      end
      default:         reg_rerr = 1'b1;
    endcase
  end

  // qualification and ranking of maskable sources
  assign active = enable_q & pending_q;
  vui_prio_enc #(.N(VUI_NSRC), .IW(4)) u_rank (
    .req   (active),
    .found (found),
    .index (top_idx)
  );

  // boundary decision; the trap latch and a running sequence hold off
  // maskable sources, a fetched trap opcode is held off only by a running sequence or a same-cycle take
  assign take   = instr_boundary && !busy_q && gie_q && found &&
                  !trap_pend_q;
  assign st_hit = instr_boundary && !busy_q && !take &&
                  next_opcode == VUI_FORCED_TRAP_OPCODE;
  assign ir_force  = take;
  assign ir_opcode = VUI_FORCED_TRAP_OPCODE;
  assign trap_busy = busy_q;
  assign trap_pc_value     = VUI_TRAP_ENTRY;
  assign global_irq_enable = gie_q;
  assign sw_trap_pending   = trap_pend_q;

  // enable and pending flags; hardware never clears a pending bit,
  // software clears by writing one and a same-cycle event wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_q  <= VUI_ENABLE_RST;
      pending_q <= VUI_PENDING_RST;
    end else begin
      if (wr_en) begin
        enable_q <= (enable_q & ~wmask[VUI_NSRC-1:0]) |
                    (reg_wdata[VUI_NSRC-1:0] & wmask[VUI_NSRC-1:0]);
      end
      pending_q <= (pending_q & ~({VUI_NSRC{wr_pend}} &
                    reg_wdata[VUI_NSRC-1:0] & wmask[VUI_NSRC-1:0])) |
                   src_event;
    end
  end

  // global enable: forced trap entry clears it, return sets it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gie_q <= VUI_GIE_RST;
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (exec_return_from_irq_instr) begin
      gie_q <= 1'b1;
    end else if (wr_ctrl && reg_wstrb[0]) begin
      gie_q <= reg_wdata[VUI_CTRL_GIE_BIT];
    end
  end

  // hidden trap latch; a new trap wins over a same-cycle clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trap_pend_q <= 1'b0;
    end else if (st_hit) begin
      trap_pend_q <= 1'b1;
    end else if (exec_clear_trap_pending_instr) begin
      trap_pend_q <= 1'b0;
    end
  end

  // trap sequence: push on the first cycle, entry load on the seventh
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q         <= 1'b0;
      cnt_q          <= 3'h0;
      trap_push_req  <= 1'b0;
      trap_push_addr <= 15'h0000;
      trap_pc_load   <= 1'b0;
    end else begin
      trap_push_req <= 1'b0;
      trap_pc_load  <= 1'b0;
      if (take || st_hit) begin
        busy_q         <= 1'b1;
        cnt_q          <= VUI_TRAP_CYCLES - 3'h1;
        trap_push_req  <= 1'b1;
        trap_push_addr <= next_pc;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          trap_pc_load <= 1'b1;
        end
        if (cnt_q == 3'h0) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

  // table page: same as the select, next one from the last byte,
  // page zero is redirected since it can never hold the table
  always_comb begin
    page = (vis_pc[7:0] == VUI_PAGE_LAST) ? vis_pc[14:8] + 7'h01
                                          : vis_pc[14:8];
    if (page == VUI_PAGE_ZERO) begin
      page = VUI_PAGE_ONE;
    end
  end

  // vector fetch: sample once at the select, then read two bytes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vs_q        <= VUI_VS_IDLE;
      rom_req     <= 1'b0;
      rom_addr    <= 15'h0000;
      tgt_hi_q    <= 7'h00;
      jump_valid  <= 1'b0;
      jump_target <= 15'h0000;
    end else begin
      jump_valid <= 1'b0;
      unique case (vs_q)
        VUI_VS_IDLE: begin
          if (exec_vis) begin
            vs_q     <= VUI_VS_HI;
            rom_req  <= 1'b1;
            rom_addr[14:8] <= page;
            if (trap_pend_q) begin
              rom_addr[7:0] <= VUI_SLOT_SW_TRAP;
            end else if (found) begin
              rom_addr[7:0] <= VUI_SLOT[top_idx];
            end else begin
              rom_addr[7:0] <= VUI_SLOT_DEFAULT;
            end
          end
        end
        VUI_VS_HI: begin
          if (rom_ack) begin
            tgt_hi_q <= rom_data[6:0];
            rom_addr <= rom_addr + 15'h0001;
            vs_q     <= VUI_VS_LO;
          end
        end
        VUI_VS_LO: begin
          if (rom_ack) begin
            rom_req     <= 1'b0;
            jump_target <= {tgt_hi_q, rom_data};
            jump_valid  <= 1'b1;
            vs_q        <= VUI_VS_JUMP;
          end
        end
        VUI_VS_JUMP: vs_q <= VUI_VS_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_trap_run;
    busy_q [*7] ##1 !busy_q;
  endsequence

  a_force_needs_active: assert property (
    ir_force |-> gie_q && (|active) && !trap_pend_q && !busy_q)
    else $error("forced trap without a qualified source");

  a_force_gie_clear: assert property (
    ir_force |=> !gie_q && trap_push_req)
    else $error("forced trap left global enable set");

  a_trap_seq_len: assert property (
    (take || st_hit) |=> s_trap_run)
    else $error("trap sequence not seven cycles");

  a_trap_entry_load: assert property (
    (take || st_hit) |-> ##7 (trap_pc_load && trap_pc_value == 15'h00FF))
    else $error("entry point not loaded at the seventh cycle");

  a_return_from_irq_instr_gie_set: assert property (
    (exec_return_from_irq_instr && !take) |=> gie_q)
    else $error("return did not set global enable");

  a_st_keeps_gie: assert property (
    (st_hit && !exec_return_from_irq_instr && !wr_ctrl) |=> trap_pend_q && $stable(gie_q))
    else $error("software trap changed global enable");

  a_trap_latch_hold: assert property (
    (trap_pend_q && !exec_clear_trap_pending_instr) |=> trap_pend_q)
    else $error("trap latch dropped without clear");

  a_pending_sticky: assert property (
    !wr_pend |=> (pending_q & $past(pending_q)) == $past(pending_q))
    else $error("pending bit cleared by hardware");

  a_vis_trap_slot: assert property (
    (exec_vis && vs_q == VUI_VS_IDLE && trap_pend_q)
      |=> rom_addr[7:0] == 8'hFE)
    else $error("trap latch did not steer vector select");

  a_vis_default: assert property (
    (exec_vis && vs_q == VUI_VS_IDLE && !trap_pend_q && !(|active))
      |=> rom_addr[7:0] == 8'hE0)
    else $error("default slot not used");

  a_page_nonzero: assert property (
    rom_req |-> rom_addr[14:8] != 7'h00)
    else $error("vector table read from page zero");
endmodule
